// File: src/roc_reg_bank.sv
/*
 * roc_reg_bank: receiver output amplitude / de-emphasis control bytes and
 * the read-only identification page of a twelve-channel optical module.
 * Assumes a single-clock byte register port driven by a management
 * controller on the same clock; read data appear one cycle after the strobe.
 */
// Summary of operation
// RULE1: six amplitude bytes, two 4-bit channel fields each, nibble top bit msb
// RULE2: host must never write amplitude codes with the msb set
// RULE3: amplitude 0111 is full scale, 0000 minimum, linear steps between
// RULE4: six de-emphasis bytes, packed identically, two fields per byte
// RULE5: de-emphasis 0111 is full 6 dB, 0000 none, msb-set codes reserved
// RULE6: intermediate de-emphasis codes give monotonic intermediate levels
// RULE7: first identification byte holds module type, zero if unspecified
// RULE8: description bits 7-6 encode the power class
// RULE9: description bits 5 and 4 flag transmit and receive clock recovery
// RULE10: description bit 3 flags a required external reference clock
// RULE11: description bit 2 flags the optional second memory page
// RULE12: description bit 1 flags controlled launch; bit 0 reserved
// RULE13: supplies byte bits 7-3 flag needed rails; bits 2-0 reserved
// RULE14: case temperature limit byte in whole degrees Celsius
// RULE15: minimum rate byte in 100 Mb/s steps, zero when unknown
// RULE16: maximum rate byte in 100 Mb/s steps, zero when unknown
// RULE17: two-byte wavelength, value over 20 is nanometres, zero unused
// RULE18: two-byte tolerance, value over 200 is nanometres, zero unused
// RULE19: flags byte bits 7-5 flag transmit fault and loss_of_signal flags
// RULE20: flags byte bit 4 flags clock recovery loss_of_lock
// RULE21: flags byte bit 3 flags squelch on loss_of_signal
// RULE22: flags bit 2 flags alarm plus warning; bits 1-0 reserved
// RULE23: amplitude fields reset to 0011
// RULE24: de-emphasis fields reset to 0000
// RULE25: identification bytes are build-time constants, writes ignored
// RULE26: reserved identification bits read zero
`timescale 1ns/1ps
module roc_reg_bank
    import roc_pkg::*;
#(
    // identification contents; defaults arbitrary and neutral
    parameter logic [7:0] TYPE_ID = 8'h00,
    parameter logic [1:0] POWER_CLASS = 2'h0,
    parameter logic TX_CLOCK_DATA_RECOVERY = 1'b0,
    parameter logic RX_CLOCK_DATA_RECOVERY = 1'b0,
    parameter logic REF_CLOCK_NEEDED = 1'b0,
    parameter logic PAGE2_PRESENT = 1'b0,
    parameter logic CONTROLLED_LAUNCH = 1'b0,
    parameter logic [4:0] SUPPLY_RAILS = 5'h00,
    parameter logic [7:0] MAX_CASE_TEMPERATURE = 8'h00,
    parameter logic [7:0] MIN_RATE = 8'h00,
    parameter logic [7:0] MAX_RATE = 8'h00,
    parameter logic [15:0] NOMINAL_WAVELENGTH = 16'h0000,
    parameter logic [15:0] WAVELENGTH_TOLERANCE = 16'h0000,
    parameter logic [5:0] SUPPORTED_FLAGS = 6'h00
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    output logic [47:0] ampCode,
    output logic [47:0] deempCode,
    output logic [11:0] codeFault
);

    // control bytes, index 0 is the lowest address
    logic [7:0] ampByte_q [ROC_CTRL_BYTES];
    logic [7:0] deempByte_q [ROC_CTRL_BYTES];

    // one write select per control byte; at most one is high per cycle
    logic [ROC_CTRL_BYTES-1:0] ampSel;
    logic [ROC_CTRL_BYTES-1:0] deempSel;

    // stored fields by channel number, taken straight from the bytes
    logic [ROC_CODE_W-1:0] ampField [ROC_CHANNELS];
    logic [ROC_CODE_W-1:0] deempField [ROC_CHANNELS];

    // values the channel output flops take at the next edge
    logic [ROC_CODE_W-1:0] ampCode_d [ROC_CHANNELS];
    logic [ROC_CODE_W-1:0] deempCode_d [ROC_CHANNELS];
    logic [ROC_CHANNELS-1:0] codeFault_d;

    // read path: which page is addressed and what each page returns
    logic idHit;
    logic ctrlHit;
    logic [7:0] idData;
    logic [7:0] ctrlData;
    logic [7:0] rdata_d;

    // constant identification bytes, reserved bits forced low
    localparam logic [7:0] DESCR_BYTE = {POWER_CLASS, TX_CLOCK_DATA_RECOVERY,
        RX_CLOCK_DATA_RECOVERY, REF_CLOCK_NEEDED, PAGE2_PRESENT,
        CONTROLLED_LAUNCH, 1'b0} & ROC_DESCR_MASK; // RULE8 RULE9 RULE10 RULE11 RULE12 RULE26
    localparam logic [7:0] SUPPLY_BYTE = {SUPPLY_RAILS, 3'h0} & ROC_SUPPLIES_MASK; // RULE13 RULE26
    localparam logic [7:0] FLAGS_BYTE = {SUPPORTED_FLAGS, 2'h0} & ROC_FLAGS_MASK; // RULE19 RULE20 RULE21 RULE22 RULE26

    function automatic logic inRange(input logic [7:0] a, input logic [7:0] lo,
                                     input logic [7:0] hi);
        inRange = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [2:0] byteIndex(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] diff;
        diff = a - base;
        byteIndex = diff[2:0];
    endfunction

    // a code with its top bit set is reserved in both field kinds
    function automatic logic codeReserved(input logic [ROC_CODE_W-1:0] code);
        codeReserved = code[ROC_CODE_W-1];
    endfunction

    // reserved codes become the top legal setting, so the analog stage
    // never sees an undefined level; software still reads what it wrote
    function automatic logic [ROC_CODE_W-1:0] clampCode(input logic [ROC_CODE_W-1:0] code);
        if (codeReserved(code)) begin
            clampCode = ROC_CODE_MAX;
        end else begin
            clampCode = code;
        end
    endfunction

    // identification page: type byte up to the supported-flags byte
    function automatic logic isIdAddr(input logic [7:0] a);
        isIdAddr = inRange(a, ROC_ADDR_TYPE_ID, ROC_ADDR_FLAGS);
    endfunction

    // control page: first amplitude byte up to the last de-emphasis byte
    function automatic logic isCtrlAddr(input logic [7:0] a);
        isCtrlAddr = inRange(a, ROC_ADDR_AMP_FIRST, ROC_ADDR_DEEMP_LAST);
    endfunction

    // write selects; identification addresses have none, so a write
    // there falls through and leaves the page untouched
    genvar bn;
    generate
        for (bn = 0; bn < ROC_CTRL_BYTES; bn++) begin : gSel
            localparam logic [7:0] AMP_ADDR = ROC_ADDR_AMP_FIRST + 8'(bn);
            localparam logic [7:0] DEEMP_ADDR = ROC_ADDR_DEEMP_FIRST + 8'(bn);
            assign ampSel[bn] = regWrite && (regAddr == AMP_ADDR); // RULE1
            assign deempSel[bn] = regWrite && (regAddr == DEEMP_ADDR); // RULE4
        end
    endgenerate

    // amplitude bytes; reserved codes are stored as written and only
    // clamped on the way out
    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int i = 0; i < ROC_CTRL_BYTES; i++) begin
                ampByte_q[i] <= {ROC_AMP_RESET, ROC_AMP_RESET}; // RULE23
            end
        end else begin
            for (int i = 0; i < ROC_CTRL_BYTES; i++) begin
                if (ampSel[i]) begin
                    ampByte_q[i] <= regWdata; // RULE1
                end
            end
        end
    end

    // de-emphasis bytes, same packing as the amplitude bytes
    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int i = 0; i < ROC_CTRL_BYTES; i++) begin
                deempByte_q[i] <= {ROC_DEEMP_RESET, ROC_DEEMP_RESET}; // RULE24
            end
        end else begin
            for (int i = 0; i < ROC_CTRL_BYTES; i++) begin
                if (deempSel[i]) begin
                    deempByte_q[i] <= regWdata; // RULE4
                end
            end
        end
    end

    // byte k holds channel 11-2k in its upper nibble, 10-2k in its lower
    genvar ch;
    generate
        for (ch = 0; ch < ROC_CHANNELS; ch++) begin : gField
            localparam int BI = ROC_CTRL_BYTES - 1 - ch / 2;
            localparam int LO = (ch % 2) * ROC_CODE_W;
            assign ampField[ch] = ampByte_q[BI][LO +: ROC_CODE_W]; // RULE1
            assign deempField[ch] = deempByte_q[BI][LO +: ROC_CODE_W]; // RULE4
        end
    endgenerate

    // clamp and fault per channel; the fault bit tells software that a
    // stored code is not the one driving the analog stage
    always_comb begin
        codeFault_d = '0;
        for (int c = 0; c < ROC_CHANNELS; c++) begin
            ampCode_d[c] = clampCode(ampField[c]); // RULE3 RULE2
            deempCode_d[c] = clampCode(deempField[c]); // RULE5 RULE6
            codeFault_d[c] = codeReserved(ampField[c]) | codeReserved(deempField[c]); // RULE5
        end
    end

    // channel output flops, so the analog side sees only registered codes
    generate
        for (ch = 0; ch < ROC_CHANNELS; ch++) begin : gChan
            always_ff @(posedge clock) begin
                if (!rstn) begin
                    ampCode[ch*ROC_CODE_W +: ROC_CODE_W] <= ROC_AMP_RESET; // RULE23
                    deempCode[ch*ROC_CODE_W +: ROC_CODE_W] <= ROC_DEEMP_RESET; // RULE24
                    codeFault[ch] <= 1'b0;
                end else begin
                    ampCode[ch*ROC_CODE_W +: ROC_CODE_W] <= ampCode_d[ch]; // RULE3
                    deempCode[ch*ROC_CODE_W +: ROC_CODE_W] <= deempCode_d[ch]; // RULE5
                    codeFault[ch] <= codeFault_d[ch];
                end
            end
        end
    endgenerate

    // identification page from build-time constants only; no register
    // holds it, so host writes cannot disturb it
    always_comb begin
        idData = 8'h00;
        if (regAddr == ROC_ADDR_TYPE_ID) begin
            idData = TYPE_ID; // RULE7 RULE25
        end else if (regAddr == ROC_ADDR_DESCR) begin
            idData = DESCR_BYTE; // RULE8 RULE9 RULE10 RULE11 RULE12
        end else if (regAddr == ROC_ADDR_SUPPLIES) begin
            idData = SUPPLY_BYTE; // RULE13
        end else if (regAddr == ROC_ADDR_MAX_TC) begin
            idData = MAX_CASE_TEMPERATURE; // RULE14
        end else if (regAddr == ROC_ADDR_MIN_RATE) begin
            idData = MIN_RATE; // RULE15
        end else if (regAddr == ROC_ADDR_MAX_RATE) begin
            idData = MAX_RATE; // RULE16
        end else if (regAddr == ROC_ADDR_WAVE_HI) begin
            idData = NOMINAL_WAVELENGTH[15:8]; // RULE17
        end else if (regAddr == ROC_ADDR_WAVE_LO) begin
            idData = NOMINAL_WAVELENGTH[7:0]; // RULE17
        end else if (regAddr == ROC_ADDR_TOL_HI) begin
            idData = WAVELENGTH_TOLERANCE[15:8]; // RULE18
        end else if (regAddr == ROC_ADDR_TOL_LO) begin
            idData = WAVELENGTH_TOLERANCE[7:0]; // RULE18
        end else if (regAddr == ROC_ADDR_FLAGS) begin
            idData = FLAGS_BYTE; // RULE19 RULE20 RULE21 RULE22
        end
    end

    // control page read back exactly as stored, reserved codes included
    always_comb begin
        ctrlData = 8'h00;
        if (inRange(regAddr, ROC_ADDR_AMP_FIRST, ROC_ADDR_AMP_LAST)) begin
            ctrlData = ampByte_q[byteIndex(regAddr, ROC_ADDR_AMP_FIRST)]; // RULE1
        end else if (inRange(regAddr, ROC_ADDR_DEEMP_FIRST, ROC_ADDR_DEEMP_LAST)) begin
            ctrlData = deempByte_q[byteIndex(regAddr, ROC_ADDR_DEEMP_FIRST)]; // RULE4
        end
    end

    // page hits; unmapped addresses hit neither and read zero
    assign idHit = isIdAddr(regAddr);
    assign ctrlHit = isCtrlAddr(regAddr);

    // read data before the output flop
    always_comb begin
        rdata_d = 8'h00;
        if (idHit) begin
            rdata_d = idData; // RULE25
        end else if (ctrlHit) begin
            rdata_d = ctrlData;
        end
    end

    // read data held only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (!rstn) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= rdata_d;
        end else begin
            regRdata <= 8'h00;
        end
    end

endmodule

// File: shared/roc_pkg.sv
/*
 * roc_pkg: register map, field layout, reset codes and identification
 * reserved-bit masks for the receiver output control and identification page bank.
 * Assumes a byte-wide register port with 8-bit addresses.
 */
package roc_pkg;
    localparam int ROC_CHANNELS = 12;
    localparam int ROC_CTRL_BYTES = 6;
    localparam int ROC_CODE_W = 4;

    // register byte addresses
    localparam logic [7:0] ROC_ADDR_TYPE_ID = 8'h80;
    localparam logic [7:0] ROC_ADDR_DESCR = 8'h81;
    localparam logic [7:0] ROC_ADDR_SUPPLIES = 8'h82;
    localparam logic [7:0] ROC_ADDR_MAX_TC = 8'h83;
    localparam logic [7:0] ROC_ADDR_MIN_RATE = 8'h84;
    localparam logic [7:0] ROC_ADDR_MAX_RATE = 8'h85;
    localparam logic [7:0] ROC_ADDR_WAVE_HI = 8'h86;
    localparam logic [7:0] ROC_ADDR_WAVE_LO = 8'h87;
    localparam logic [7:0] ROC_ADDR_TOL_HI = 8'h88;
    localparam logic [7:0] ROC_ADDR_TOL_LO = 8'h89;
    localparam logic [7:0] ROC_ADDR_FLAGS = 8'h8a;
    localparam logic [7:0] ROC_ADDR_AMP_FIRST = 8'he4;
    localparam logic [7:0] ROC_ADDR_AMP_LAST = 8'he9;
    localparam logic [7:0] ROC_ADDR_DEEMP_FIRST = 8'hea;
    localparam logic [7:0] ROC_ADDR_DEEMP_LAST = 8'hef;

    // field reset codes and the clamp code for reserved values
    localparam logic [3:0] ROC_AMP_RESET = 4'h3;
    localparam logic [3:0] ROC_DEEMP_RESET = 4'h0;
    localparam logic [3:0] ROC_CODE_MAX = 4'h7;

    // reserved-bit masks of identification bytes
    localparam logic [7:0] ROC_DESCR_MASK = 8'hfe;
    localparam logic [7:0] ROC_SUPPLIES_MASK = 8'hf8;
    localparam logic [7:0] ROC_FLAGS_MASK = 8'hfc;

    // amplitude levels in mVpp: base plus code times step; full de-emphasis in dB
    localparam int ROC_AMP_MIN_MV = 220;
    localparam int ROC_AMP_STEP_MV = 90;
    localparam int ROC_DEEMP_FULL_DB = 6;
endpackage

// File: tb/roc_reg_bank_props.sv
/* roc_reg_bank_props: port-level checks of the control and id bank.
   assumes it is bound to every roc_reg_bank instance. */
`timescale 1ns/1ps
module roc_reg_bank_props (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    input wire logic [47:0] ampCode,
    input wire logic [47:0] deempCode,
    input wire logic [11:0] codeFault
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // codes reach the outputs two edges after the write strobe
    AST_AMP_LOW: assert property (
        regWrite && regAddr == 8'he9 && !regWdata[3] |-> ##2 ampCode[3:0] == $past(regWdata[3:0], 2))
        else $error("channel 0 amplitude not applied");
    AST_AMP_HIGH: assert property (
        regWrite && regAddr == 8'he4 && !regWdata[7] |-> ##2 ampCode[47:44] == $past(regWdata[7:4], 2))
        else $error("channel 11 amplitude not applied");
    AST_DEEMP: assert property (
        regWrite && regAddr == 8'hef && !regWdata[7] |-> ##2 deempCode[7:4] == $past(regWdata[7:4], 2))
        else $error("channel 1 de-emphasis not applied");
    // reserved codes must never reach the analog side
    AST_CLAMP: assert property (
        regWrite && regAddr == 8'he9 && regWdata[3] |-> ##2 ampCode[3:0] == 4'h7 && codeFault[0])
        else $error("reserved amplitude not clamped");
    AST_LEGAL: assert property (
        ((ampCode | deempCode) & 48'h888888888888) == 48'h0)
        else $error("reserved code on output");
    AST_HOLD: assert property (
        !regWrite |-> ##2 $stable(ampCode) && $stable(deempCode))
        else $error("codes moved without a write");
    AST_RESET_AMP: assert property (
        $rose(rstn) |-> ampCode == 48'h333333333333)
        else $error("amplitude reset code wrong");
    AST_RESET_DEEMP: assert property (
        $rose(rstn) |-> deempCode == 48'h0 && codeFault == 12'h000)
        else $error("de-emphasis reset code wrong");
    AST_DESCR_RSVD: assert property (
        regRead && regAddr == 8'h81 |=> regRdata[0] == 1'b0)
        else $error("description reserved bit set");
    AST_SUPPLY_RSVD: assert property (
        regRead && regAddr == 8'h82 |=> regRdata[2:0] == 3'h0)
        else $error("supplies reserved bits set");
    AST_FLAGS_RSVD: assert property (
        regRead && regAddr == 8'h8a |=> regRdata[1:0] == 2'h0)
        else $error("flags reserved bits set");
    cover property (regWrite && regAddr[7:4] == 4'he);
    cover property (codeFault != 12'h000);
    cover property (regRead && regAddr == 8'h8a);
endmodule
bind roc_reg_bank roc_reg_bank_props props_u (.clock(clock), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .ampCode(ampCode), .deempCode(deempCode), .codeFault(codeFault));

// File: tb/roc_reg_bank_test.sv
/* roc_reg_bank_test: directed bench for the control and id bank.
   assumes the package and the checker are compiled before it. */
`timescale 1ns/1ps
module roc_reg_bank_test;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regRdata, q;
    logic [47:0] ampCode, deempCode;
    logic [11:0] codeFault;
    int nErrors = 0;
    int nCompared = 0;
    // address, byte written, byte read back; id bytes must ignore the write
    logic [23:0] rows [26] = '{24'h80ff5a, 24'h81ffea, 24'h82ffa8, 24'h83ff46, 24'h84ff0a,
        24'h85ff32, 24'h86ff42, 24'h87ff68, 24'h88ff07, 24'h89ffd0, 24'h8affac, 24'h8bff00,
        24'h00ff00, 24'hf0ff00, 24'he47676, 24'he55454, 24'he63232, 24'he71010, 24'he80101,
        24'he92323, 24'hea0707, 24'heb7070, 24'hec1616, 24'hed6161, 24'hee2525, 24'hef5252};
    // identification contents under test; values arbitrary
    localparam logic [7:0] TYPE_V = 8'h5a, TEMP_V = 8'h46, MIN_V = 8'h0a, MAX_V = 8'h32;
    localparam logic [15:0] WAVE_V = 16'h4268, TOL_V = 16'h07d0;
    localparam logic [1:0] POWER_V = 2'h3;
    localparam logic [4:0] RAILS_V = 5'h15;
    localparam logic [5:0] FLAGS_V = 6'h2b;
    localparam logic TX_V = 1'b1, RX_V = 1'b0, REF_V = 1'b1, PG2_V = 1'b0, LAUNCH_V = 1'b1;
    always #5 clock = ~clock;
    roc_reg_bank #(.TYPE_ID(TYPE_V), .POWER_CLASS(POWER_V), .TX_CLOCK_DATA_RECOVERY(TX_V),
        .RX_CLOCK_DATA_RECOVERY(RX_V), .REF_CLOCK_NEEDED(REF_V), .PAGE2_PRESENT(PG2_V),
        .CONTROLLED_LAUNCH(LAUNCH_V), .SUPPLY_RAILS(RAILS_V), .MAX_CASE_TEMPERATURE(TEMP_V),
        .MIN_RATE(MIN_V), .MAX_RATE(MAX_V), .NOMINAL_WAVELENGTH(WAVE_V),
        .WAVELENGTH_TOLERANCE(TOL_V), .SUPPORTED_FLAGS(FLAGS_V)) dut_u (.clock(clock),
        .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .ampCode(ampCode), .deempCode(deempCode),
        .codeFault(codeFault));
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nErrors++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus cycle; read data captured just after the strobe edge
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        regWrite <= w;
        regRead <= r;
        regAddr <= a;
        regWdata <= d;
        @(posedge clock);
        #1 q = regRdata;
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", nCompared, nErrors);
        if (nErrors == 0 && nCompared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // generous bound: the sequence needs under 100 cycles
    initial begin
        repeat (500) @(posedge clock);
        nErrors++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        op(1'b0, 1'b0, 8'h00, 8'h00);
        chk(ampCode, 48'h333333333333);
        chk(deempCode, 48'h0);
        $display("reset test done");
        // write then read back with no gap between the strobes
        foreach (rows[i]) begin
            op(1'b1, 1'b0, rows[i][23:16], rows[i][15:8]);
            op(1'b0, 1'b1, rows[i][23:16], 8'h00);
            chk(q, rows[i][7:0]);
        end
        op(1'b0, 1'b0, 8'h00, 8'h00);
        chk(ampCode, 48'h765432100123);
        chk(deempCode, 48'h077016612552);
        chk(codeFault, 12'h000);
        $display("register rows done");
        // reserved codes read back as written but clamp on the outputs
        op(1'b1, 1'b0, 8'he9, 8'h8f);
        op(1'b0, 1'b1, 8'he9, 8'h00);
        chk(q, 8'h8f);
        op(1'b0, 1'b0, 8'h00, 8'h00);
        chk(regRdata, 8'h00);
        chk(ampCode[7:0], 8'h77);
        chk(codeFault, 12'h003);
        $display("reserved code test done");
        rstn <= 1'b0;
        op(1'b0, 1'b0, 8'h00, 8'h00);
        op(1'b0, 1'b0, 8'h00, 8'h00);
        rstn <= 1'b1;
        op(1'b0, 1'b0, 8'h00, 8'h00);
        op(1'b0, 1'b1, 8'he9, 8'h00);
        chk(q, 8'h33);
        chk(codeFault, 12'h000);
        chk(deempCode, 48'h0);
        $display("second reset test done");
        summarize();
    end
endmodule
